// file: mesr_pkg.sv
// Constants, types and state layout of the motion event status register group
//
// Operation
// - Wake-up source byte shows live sleep state: 0 active, 1 inactive, reset 0.
// - Activity-change and free-fall flags set on their events, reset 0.
// - Wake-up flag with X, Y, Z cause flags, all reset 0.
// - Any-tap flag plus single-tap and double-tap type flags, reset 0.
// - Tap sign bit, 0 positive, 1 negative, plus per-axis tap flags.
// - Orientation change flag plus six axis high/low threshold flags.
// - Single-write-complete flag reported from the auxiliary master.
// - Four not-acknowledge flags, one per external target 0 to 3.
// - Aux cycle done reads 1 when concluded, 0 while pending.
// - Long-counter, significant motion, tilt and step status mirrored.
// - Eight state machine event bits, one per machine.
// - Four classifier bits in low nibble, upper nibble reads 0.
// - Read-only signed 8-bit oscillator trim, 0.13 percent per step.
// - Timestamp tick period is 1/(46080*(1+0.0013*trim)) seconds.
// - Output rate is 7680*(1+0.0013*trim)/coefficient, coefficient 1024..1.
// - Basic interrupts produced only while interrupt enable bit is 1.
// - Timestamp counter runs only while enabled; read as four bytes.
// - Summary source read clears latched flags unless keep bit is 1.
// - Inactivity policy 00 irq only, 01 accel low power, 10/11 gyro too.
// - Pin level stamped into LSB of selected axes of chosen sensor.
// - Level trigger, level latch and accel extension enables, extend default 0.
// - Enable pattern 10 selects level trigger, 11 level latched mode.
// - Inactive accel rate field: 1.875, 15, 30, 60 Hz.
// - Latch config 1 holds interrupt flags, 0 passes them through.
package mesr_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_SUMMARY   = 8'h1d;
  localparam logic [7:0] ADDR_TS0       = 8'h40;
  localparam logic [7:0] ADDR_TS3       = 8'h43;
  localparam logic [7:0] ADDR_WAKE      = 8'h45;
  localparam logic [7:0] ADDR_TAP       = 8'h46;
  localparam logic [7:0] ADDR_ORIENT    = 8'h47;
  localparam logic [7:0] ADDR_AUX       = 8'h48;
  localparam logic [7:0] ADDR_EMB       = 8'h49;
  localparam logic [7:0] ADDR_SM        = 8'h4a;
  localparam logic [7:0] ADDR_CLASS     = 8'h4b;
  localparam logic [7:0] ADDR_TRIM      = 8'h4f;
  localparam logic [7:0] ADDR_FUNC      = 8'h50;
  localparam logic [7:0] ADDR_STAMP     = 8'h51;

  // ************************************************************
  // Fields, masks and reset values
  // ************************************************************
  localparam logic [7:0] FUNC_WMASK     = 8'hcb;
  localparam logic [7:0] FUNC_RESET     = 8'h00;
  localparam int         FUNC_IRQ_EN    = 7;
  localparam int         FUNC_TS_EN     = 6;
  localparam int         FUNC_KEEP      = 3;
  localparam int         FUNC_POL_MSB   = 1;
  localparam int         FUNC_POL_LSB   = 0;
  localparam logic [7:0] STAMP_WMASK    = 8'h7f;
  localparam logic [7:0] STAMP_RESET    = 8'h0e;
  localparam int         STAMP_TRIG     = 6;
  localparam int         STAMP_LATCH    = 5;
  localparam int         STAMP_EXT      = 4;
  localparam int         STAMP_X        = 3;
  localparam int         STAMP_Y        = 2;
  localparam int         STAMP_Z        = 1;
  localparam int         STAMP_SEL      = 0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int         CLK_HZ         = 40_000_000;
  localparam int         TS_TICK_HZ     = 46080;
  localparam int         TS_DIV_CYCLES  = CLK_HZ / TS_TICK_HZ;
  localparam logic [9:0] TS_DIV_LAST    = 10'(TS_DIV_CYCLES - 1);

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {STAMP_OFF, STAMP_LEVEL_TRIG, STAMP_LEVEL_LATCH} mesr_stamp_mode_t;
  typedef enum logic [1:0] {POL_IRQ_ONLY, POL_ACCEL_LP, POL_GYRO_SLEEP,
                            POL_GYRO_OFF} mesr_policy_t;

  typedef struct packed {
    logic       activity_change;
    logic       freefall;
    logic       wakeup;
    logic [2:0] wake_axes;
    logic       tap_any;
    logic       single_tap;
    logic       double_tap;
    logic       tap_sign;
    logic [2:0] tap_axes;
    logic       orient_change;
    logic [5:0] orient_axes;
  } mesr_motion_evt_t;

  typedef struct packed {
    logic       single_write_complete;
    logic [3:0] target_noack;
    logic       aux_cycle_done;
  } mesr_aux_status_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } mesr_axes_t;

  typedef struct packed {
    logic [5:0]  wake_flags;
    logic [6:0]  tap_flags;
    logic [6:0]  orient_flags;
    logic [7:0]  func_en;
    logic [7:0]  stamp_cfg;
    logic [31:0] ts_count;
    logic [9:0]  ts_div;
    logic [1:0]  pin_sync;
    logic        pin_held;
    logic [7:0]  rdata;
    logic [2:0]  power;
    logic        irq;
    mesr_axes_t  gyro_out;
    mesr_axes_t  accel_out;
  } mesr_state_t;

endpackage : mesr_pkg

// file: mesr_top.sv
// Event status, function enable and stamping register group
`timescale 1ns/1ps
module mesr_top (
  input  wire logic                      clk_sys_i,
  input  wire logic                      nrst_i,
  input  wire logic [7:0]                reg_addr_i,
  input  wire logic                      reg_wr_i,
  input  wire logic [7:0]                reg_wdata_i,
  input  wire logic                      reg_rd_i,
  output      logic [7:0]                reg_rdata_o,
  input  wire mesr_pkg::mesr_motion_evt_t motion_evt_i,
  input  wire logic                      sleep_state_i,
  input  wire logic                      latch_irq_config_i,
  input  wire logic [1:0]                inactive_accel_rate_i,
  input  wire mesr_pkg::mesr_aux_status_t aux_status_i,
  input  wire logic [7:0]                embedded_status_i,
  input  wire logic [7:0]                state_machine_event_bits_i,
  input  wire logic [3:0]                classifier_event_bits_i,
  input  wire logic [7:0]                oscillator_trim_value_i,
  input  wire logic                      data_enable_stamp_pin_i,
  input  wire mesr_pkg::mesr_axes_t      gyro_sample_i,
  input  wire mesr_pkg::mesr_axes_t      accel_sample_i,
  output      mesr_pkg::mesr_axes_t      gyro_out_o,
  output      mesr_pkg::mesr_axes_t      accel_out_o,
  output      logic                      basic_irq_o,
  output      logic                      accel_low_power_o,
  output      logic                      gyro_sleep_o,
  output      logic                      gyro_power_down_o,
  output      logic [1:0]                accel_inactive_rate_o
);

  mesr_pkg::mesr_state_t      s_reg;
  mesr_pkg::mesr_state_t      s_next;
  mesr_pkg::mesr_stamp_mode_t stamp_mode;
  mesr_pkg::mesr_policy_t     policy;
  logic                       rd_sum_clr;
  logic                       clr_wake;
  logic                       clr_tap;
  logic                       clr_orient;
  logic                       irq_en;
  logic [5:0]                 ev_wake;
  logic [6:0]                 ev_tap;
  logic [6:0]                 ev_orient;
  logic                       stamp_val;
  logic                       stamp_gyro;
  logic                       stamp_accel;

  // ************************************************************
  // Decode of configuration
  // ************************************************************
  always_comb begin
    irq_en = s_reg.func_en[mesr_pkg::FUNC_IRQ_EN];
    policy = mesr_pkg::mesr_policy_t'(s_reg.func_en[mesr_pkg::FUNC_POL_MSB:
                                                    mesr_pkg::FUNC_POL_LSB]);
    if ({s_reg.stamp_cfg[mesr_pkg::STAMP_TRIG], s_reg.stamp_cfg[mesr_pkg::STAMP_LATCH]}
        == 2'b10) begin
      stamp_mode = mesr_pkg::STAMP_LEVEL_TRIG;
    end else if ({s_reg.stamp_cfg[mesr_pkg::STAMP_TRIG],
                  s_reg.stamp_cfg[mesr_pkg::STAMP_LATCH]} == 2'b11) begin
      stamp_mode = mesr_pkg::STAMP_LEVEL_LATCH;
    end else begin
      stamp_mode = mesr_pkg::STAMP_OFF;
    end
    // Pin level only, or any high since the last sample in latched mode
    stamp_val   = (stamp_mode == mesr_pkg::STAMP_LEVEL_LATCH) ?
                  (s_reg.pin_held | s_reg.pin_sync[1]) : s_reg.pin_sync[1];
    stamp_gyro  = (stamp_mode != mesr_pkg::STAMP_OFF) &&
                  !s_reg.stamp_cfg[mesr_pkg::STAMP_SEL];
    stamp_accel = (stamp_mode != mesr_pkg::STAMP_OFF) &&
                  (s_reg.stamp_cfg[mesr_pkg::STAMP_SEL] ||
                   s_reg.stamp_cfg[mesr_pkg::STAMP_EXT]);
  end

  // ************************************************************
  // Event gating and clear-on-read
  // ************************************************************
  always_comb begin
    // Detectors are masked while basic interrupts are off
    ev_wake   = {motion_evt_i.activity_change, motion_evt_i.freefall,
                 motion_evt_i.wakeup, motion_evt_i.wake_axes} & {6{irq_en}};
    ev_tap    = {motion_evt_i.tap_any, motion_evt_i.single_tap, motion_evt_i.double_tap,
                 motion_evt_i.tap_sign, motion_evt_i.tap_axes} & {7{irq_en}};
    ev_orient = {motion_evt_i.orient_change, motion_evt_i.orient_axes} & {7{irq_en}};
    rd_sum_clr = reg_rd_i && (reg_addr_i == mesr_pkg::ADDR_SUMMARY) &&
                 !s_reg.func_en[mesr_pkg::FUNC_KEEP];
    clr_wake   = rd_sum_clr || (reg_rd_i && (reg_addr_i == mesr_pkg::ADDR_WAKE));
    clr_tap    = rd_sum_clr || (reg_rd_i && (reg_addr_i == mesr_pkg::ADDR_TAP));
    clr_orient = rd_sum_clr || (reg_rd_i && (reg_addr_i == mesr_pkg::ADDR_ORIENT));
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_next = s_reg;

    // Set wins over a clear arriving in the same cycle
    if (latch_irq_config_i) begin
      s_next.wake_flags   = (s_reg.wake_flags & ~{6{clr_wake}}) | ev_wake;
      s_next.tap_flags    = (s_reg.tap_flags & ~{7{clr_tap}}) | ev_tap;
      s_next.orient_flags = (s_reg.orient_flags & ~{7{clr_orient}}) | ev_orient;
    end else begin
      s_next.wake_flags   = ev_wake;
      s_next.tap_flags    = ev_tap;
      s_next.orient_flags = ev_orient;
    end

    // Reserved bits are forced low whatever the host writes
    if (reg_wr_i && (reg_addr_i == mesr_pkg::ADDR_FUNC)) begin
      s_next.func_en = reg_wdata_i & mesr_pkg::FUNC_WMASK;
    end
    if (reg_wr_i && (reg_addr_i == mesr_pkg::ADDR_STAMP)) begin
      s_next.stamp_cfg = reg_wdata_i & mesr_pkg::STAMP_WMASK;
    end

    // Tick is the nominal rate; trim tells software the true period
    if (s_reg.func_en[mesr_pkg::FUNC_TS_EN]) begin
      if (s_reg.ts_div == mesr_pkg::TS_DIV_LAST) begin
        s_next.ts_div   = 10'h000;
        s_next.ts_count = s_reg.ts_count + 32'h0000_0001;
      end else begin
        s_next.ts_div = s_reg.ts_div + 10'h001;
      end
    end else begin
      s_next.ts_div = 10'h000;
    end

    s_next.pin_sync = {s_reg.pin_sync[0], data_enable_stamp_pin_i};
    s_next.pin_held = s_reg.pin_sync[1] |
                      (s_reg.pin_held & ~(gyro_sample_i.valid | accel_sample_i.valid));

    s_next.gyro_out.valid = gyro_sample_i.valid;
    if (gyro_sample_i.valid) begin
      s_next.gyro_out.x = gyro_sample_i.x;
      s_next.gyro_out.y = gyro_sample_i.y;
      s_next.gyro_out.z = gyro_sample_i.z;
      if (stamp_gyro && s_reg.stamp_cfg[mesr_pkg::STAMP_X]) begin
        s_next.gyro_out.x[0] = stamp_val;
      end
      if (stamp_gyro && s_reg.stamp_cfg[mesr_pkg::STAMP_Y]) begin
        s_next.gyro_out.y[0] = stamp_val;
      end
      if (stamp_gyro && s_reg.stamp_cfg[mesr_pkg::STAMP_Z]) begin
        s_next.gyro_out.z[0] = stamp_val;
      end
    end
    s_next.accel_out.valid = accel_sample_i.valid;
    if (accel_sample_i.valid) begin
      s_next.accel_out.x = accel_sample_i.x;
      s_next.accel_out.y = accel_sample_i.y;
      s_next.accel_out.z = accel_sample_i.z;
      if (stamp_accel && s_reg.stamp_cfg[mesr_pkg::STAMP_X]) begin
        s_next.accel_out.x[0] = stamp_val;
      end
      if (stamp_accel && s_reg.stamp_cfg[mesr_pkg::STAMP_Y]) begin
        s_next.accel_out.y[0] = stamp_val;
      end
      if (stamp_accel && s_reg.stamp_cfg[mesr_pkg::STAMP_Z]) begin
        s_next.accel_out.z[0] = stamp_val;
      end
    end

    // Power policy acts only while the device is inactive
    s_next.power[0] = sleep_state_i && (policy != mesr_pkg::POL_IRQ_ONLY);
    s_next.power[1] = sleep_state_i && (policy == mesr_pkg::POL_GYRO_SLEEP);
    s_next.power[2] = sleep_state_i && (policy == mesr_pkg::POL_GYRO_OFF);

    s_next.irq = irq_en && (s_reg.wake_flags[5] | s_reg.wake_flags[4] |
                            s_reg.wake_flags[3] | s_reg.tap_flags[6] |
                            s_reg.orient_flags[6]);

    // Read data; status registers ignore writes
    if (reg_addr_i == mesr_pkg::ADDR_SUMMARY) begin
      s_next.rdata = {2'b00, s_reg.wake_flags[5], s_reg.orient_flags[6],
                      s_reg.tap_flags[4], s_reg.tap_flags[5],
                      s_reg.wake_flags[3], s_reg.wake_flags[4]};
    end else if ((reg_addr_i >= mesr_pkg::ADDR_TS0) &&
                 (reg_addr_i <= mesr_pkg::ADDR_TS3)) begin
      s_next.rdata = 8'(s_reg.ts_count >> {reg_addr_i[1:0], 3'b000});
    end else if (reg_addr_i == mesr_pkg::ADDR_WAKE) begin
      s_next.rdata = {1'b0, s_reg.wake_flags[5:4], sleep_state_i,
                      s_reg.wake_flags[3:0]};
    end else if (reg_addr_i == mesr_pkg::ADDR_TAP) begin
      s_next.rdata = {1'b0, s_reg.tap_flags};
    end else if (reg_addr_i == mesr_pkg::ADDR_ORIENT) begin
      s_next.rdata = {1'b0, s_reg.orient_flags};
    end else if (reg_addr_i == mesr_pkg::ADDR_AUX) begin
      s_next.rdata = {aux_status_i.single_write_complete, aux_status_i.target_noack,
                      2'b00, aux_status_i.aux_cycle_done};
    end else if (reg_addr_i == mesr_pkg::ADDR_EMB) begin
      s_next.rdata = {embedded_status_i[7], 1'b0, embedded_status_i[5:3], 3'b000};
    end else if (reg_addr_i == mesr_pkg::ADDR_SM) begin
      s_next.rdata = state_machine_event_bits_i;
    end else if (reg_addr_i == mesr_pkg::ADDR_CLASS) begin
      s_next.rdata = {4'h0, classifier_event_bits_i};
    end else if (reg_addr_i == mesr_pkg::ADDR_TRIM) begin
      s_next.rdata = oscillator_trim_value_i;
    end else if (reg_addr_i == mesr_pkg::ADDR_FUNC) begin
      s_next.rdata = s_reg.func_en;
    end else if (reg_addr_i == mesr_pkg::ADDR_STAMP) begin
      s_next.rdata = s_reg.stamp_cfg;
    end else begin
      s_next.rdata = 8'h00;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      s_reg           <= '0;
      s_reg.func_en   <= mesr_pkg::FUNC_RESET;
      s_reg.stamp_cfg <= mesr_pkg::STAMP_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata_o           = s_reg.rdata;
  assign gyro_out_o            = s_reg.gyro_out;
  assign accel_out_o           = s_reg.accel_out;
  assign basic_irq_o           = s_reg.irq;
  assign accel_low_power_o     = s_reg.power[0];
  assign gyro_sleep_o          = s_reg.power[1];
  assign gyro_power_down_o     = s_reg.power[2];
  assign accel_inactive_rate_o = inactive_accel_rate_i;

endmodule : mesr_top

// file: README_unused.sv
// Intentionally empty

// file: mesr_checker.sv
// Port-level assertions for the motion event status register group
`timescale 1ns/1ps
module mesr_checker (
  input wire logic                       clk_sys_i,
  input wire logic                       nrst_i,
  input wire logic [7:0]                 reg_addr_i,
  input wire logic [7:0]                 reg_rdata_o,
  input wire logic                       sleep_state_i,
  input wire logic [1:0]                 inactive_accel_rate_i,
  input wire mesr_pkg::mesr_aux_status_t aux_status_i,
  input wire logic [7:0]                 embedded_status_i,
  input wire logic [7:0]                 state_machine_event_bits_i,
  input wire logic [3:0]                 classifier_event_bits_i,
  input wire logic [7:0]                 oscillator_trim_value_i,
  input wire mesr_pkg::mesr_axes_t       gyro_sample_i,
  input wire mesr_pkg::mesr_axes_t       gyro_out_o,
  input wire logic                       accel_low_power_o,
  input wire logic                       gyro_sleep_o,
  input wire logic                       gyro_power_down_o,
  input wire logic [1:0]                 accel_inactive_rate_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // ************************************************************
  // Read data, one cycle behind the address; edge after reset skipped; then power, rate and gyro output checks
  // ************************************************************
  sequence rd_at(logic [7:0] a);
    $past(nrst_i) && $past(reg_addr_i) == a;
  endsequence
  rd_wake_a: assert property (rd_at(8'h45) |-> !reg_rdata_o[7] &&
    reg_rdata_o[4] == $past(sleep_state_i)) else $error("wake byte sleep bit wrong");
  rd_aux_a: assert property (rd_at(8'h48) |-> reg_rdata_o ==
    {$past(aux_status_i[5:1]), 2'b00, $past(aux_status_i[0])}) else $error("aux byte wrong");
  rd_emb_a: assert property (rd_at(8'h49) |->
    reg_rdata_o == ($past(embedded_status_i) & 8'hb8)) else $error("embedded byte wrong");
  rd_machine_a: assert property (rd_at(8'h4a) |->
    reg_rdata_o == $past(state_machine_event_bits_i)) else $error("machine byte wrong");
  rd_class_a: assert property (rd_at(8'h4b) |->
    reg_rdata_o == {4'h0, $past(classifier_event_bits_i)}) else $error("classifier byte wrong");
  rd_trim_a: assert property (rd_at(8'h4f) |->
    reg_rdata_o == $past(oscillator_trim_value_i)) else $error("trim byte wrong");
  rd_unmapped_a: assert property (rd_at(8'h60) |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  power_awake_a: assert property (!$past(sleep_state_i) |->
    !accel_low_power_o && !gyro_sleep_o && !gyro_power_down_o) else $error("power while awake");
  power_mode_a: assert property ((gyro_sleep_o || gyro_power_down_o) |->
    accel_low_power_o && !(gyro_sleep_o && gyro_power_down_o)) else $error("power mix wrong");
  rate_copy_a: assert property (accel_inactive_rate_o == inactive_accel_rate_i)
    else $error("inactive rate not passed");
  stamp_pulse_a: assert property (1'b1 |=> gyro_out_o.valid == $past(gyro_sample_i.valid))
    else $error("gyro valid not one cycle late");
  stamp_upper_a: assert property (gyro_sample_i.valid |=>
    gyro_out_o.x[15:1] == $past(gyro_sample_i.x[15:1])) else $error("gyro upper bits changed");
endmodule : mesr_checker

bind mesr_top mesr_checker u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .sleep_state_i(sleep_state_i),
  .inactive_accel_rate_i(inactive_accel_rate_i), .aux_status_i(aux_status_i),
  .embedded_status_i(embedded_status_i), .state_machine_event_bits_i(state_machine_event_bits_i),
  .classifier_event_bits_i(classifier_event_bits_i), .gyro_out_o(gyro_out_o),
  .oscillator_trim_value_i(oscillator_trim_value_i), .gyro_sample_i(gyro_sample_i),
  .accel_low_power_o(accel_low_power_o), .gyro_sleep_o(gyro_sleep_o),
  .gyro_power_down_o(gyro_power_down_o), .accel_inactive_rate_o(accel_inactive_rate_o));

// file: mesr_host.sv
// Host processor model driving the register port
`timescale 1ns/1ps
module mesr_host (
  input  wire logic       clk_sys_i,
  output      logic [7:0] reg_addr_o,
  output      logic       reg_wr_o,
  output      logic [7:0] reg_wdata_o,
  output      logic       reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    {reg_addr_o, reg_wr_o, reg_wdata_o, reg_rd_o} = '0;
  end
  // Raw mode lets a test push reserved ones on purpose
  task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic raw);
    @(posedge clk_sys_i);
    #2;
    reg_addr_o = a;
    reg_wdata_o = raw ? dat : dat & ((a == 8'h50) ? mesr_pkg::FUNC_WMASK :
                                      mesr_pkg::STAMP_WMASK);
    reg_wr_o = 1'b1;
    @(posedge clk_sys_i);
    #2;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~reg_wdata_o;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge clk_sys_i);
    #2;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge clk_sys_i);
    #2;
    reg_rd_o = 1'b0;
    dat = reg_rdata_i;
  endtask : rd
endmodule : mesr_host

// file: motion_event_status_regs_tb.sv
// Self-checking bench for the motion event status register group
`timescale 1ns/1ps
module motion_event_status_regs_tb;
  typedef struct packed {logic [7:0] a; logic [7:0] v; logic [7:0] e;} mesr_row_t;
  typedef struct packed {logic [7:0] c; logic p; logic [15:0] x; logic [15:0] g;
                         logic [15:0] k;} mesr_srow_t;
  logic                       clk_sys_i, nrst_i, reg_wr, reg_rd, sleep, latch, pin;
  logic [7:0]                 reg_addr, reg_wdata, rdata, emb, sm, trim, d;
  logic [3:0]                 cls;
  logic [1:0]                 rate, rate_o;
  logic                       irq, lp, gsl, gpd;
  mesr_pkg::mesr_motion_evt_t evt;
  mesr_pkg::mesr_aux_status_t aux;
  mesr_pkg::mesr_axes_t       gs, acs, go, ao;
  int                         mismatches, samples_checked;
  mesr_row_t rows [15] = '{
    '{8'h50, 8'h00, 8'h00}, '{8'h51, 8'h00, 8'h0e}, '{8'h40, 8'h00, 8'h00},
    '{8'h45, 8'h01, 8'h10}, '{8'h45, 8'h00, 8'h00}, '{8'h46, 8'h00, 8'h00},
    '{8'h47, 8'h00, 8'h00}, '{8'h48, 8'h2d, 8'hb1}, '{8'h48, 8'h12, 8'h48},
    '{8'h49, 8'hff, 8'hb8}, '{8'h49, 8'h47, 8'h00}, '{8'h4a, 8'ha5, 8'ha5},
    '{8'h4b, 8'hf9, 8'h09}, '{8'h4f, 8'h80, 8'h80}, '{8'h60, 8'hff, 8'h00}};
  mesr_srow_t srows [6] = '{
    '{8'h48, 1'b1, 16'h1234, 16'h1235, 16'h1234}, '{8'h08, 1'b1, 16'h1234, 16'h1234, 16'h1234},
    '{8'h49, 1'b1, 16'h1234, 16'h1234, 16'h1235}, '{8'h58, 1'b1, 16'h1234, 16'h1235, 16'h1235},
    '{8'h48, 1'b0, 16'h1235, 16'h1234, 16'h1235}, '{8'h28, 1'b0, 16'h1235, 16'h1235, 16'h1235}};

  mesr_top dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .motion_evt_i(evt),
    .sleep_state_i(sleep), .latch_irq_config_i(latch), .inactive_accel_rate_i(rate),
    .aux_status_i(aux), .embedded_status_i(emb), .state_machine_event_bits_i(sm),
    .classifier_event_bits_i(cls), .oscillator_trim_value_i(trim),
    .data_enable_stamp_pin_i(pin), .gyro_sample_i(gs), .accel_sample_i(acs), .gyro_out_o(go),
    .accel_out_o(ao), .basic_irq_o(irq), .accel_low_power_o(lp), .gyro_sleep_o(gsl),
    .gyro_power_down_o(gpd), .accel_inactive_rate_o(rate_o));
  mesr_host host (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
    .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_rdata_i(rdata));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask : tick
  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done
  task automatic pulse(input logic [19:0] v);
    evt = v;
    tick(1);
    evt = '0;
  endtask : pulse
  // Y and Z carry even values, so a stray stamp on them shows
  task automatic samp(input logic [15:0] x, input logic [15:0] gx, input logic [15:0] ax);
    gs = {1'b1, x, 16'h5678, 16'h9abc};
    acs = gs;
    tick(1);
    gs.valid = 1'b0;
    acs.valid = 1'b0;
    chk("gyro out", go, {1'b1, gx, 16'h5678, 16'h9abc});
    chk("accel out", ao, {1'b1, ax, 16'h5678, 16'h9abc});
  endtask : samp
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #500000;
    mismatches++;
    results();
  end
  initial begin
    {nrst_i, sleep, latch, pin, cls, emb, sm, trim, evt, aux, gs, acs} = '0;
    rate = 2'b10;
    tick(2);
    nrst_i = 1'b1;
    foreach (rows[i]) begin
      case (rows[i].a)
        8'h45: sleep = rows[i].v[0];
        8'h48: aux = mesr_pkg::mesr_aux_status_t'(rows[i].v[5:0]);
        8'h49: emb = rows[i].v;
        8'h4a: sm = rows[i].v;
        8'h4b: cls = rows[i].v[3:0];
        8'h4f: trim = rows[i].v;
        default: ;
      endcase
      host.rd(rows[i].a, d);
      chk("register", d, rows[i].e);
    end
    done("table");
    latch = 1'b1;
    host.wr(8'h50, 8'h80, 1'b0);
    pulse(20'hb4000);
    tick(1);
    chk("irq", irq, 1'b1);
    host.rd(8'h45, d);
    chk("wake", d, 8'h4d);
    host.rd(8'h45, d);
    chk("wake", d, 8'h00);
    chk("irq", irq, 1'b0);
    pulse(20'h02d00);
    host.rd(8'h46, d);
    chk("tap", d, 8'h5a);
    // Event and clear in one cycle: the set must win
    fork
      host.rd(8'h46, d);
      begin
        tick(1);
        pulse(20'h02000);
      end
    join
    chk("tap", d, 8'h00);
    host.rd(8'h46, d);
    chk("tap", d, 8'h40);
    host.wr(8'h50, 8'h88, 1'b0);
    pulse(20'h00061);
    host.rd(8'h1d, d);
    chk("summary", d, 8'h10);
    host.rd(8'h47, d);
    chk("orient", d, 8'h61);
    host.wr(8'h50, 8'h80, 1'b0);
    pulse(20'h00061);
    host.rd(8'h1d, d);
    host.rd(8'h47, d);
    chk("orient", d, 8'h00);
    host.wr(8'h50, 8'h00, 1'b0);
    pulse(20'h40000);
    tick(1);
    chk("irq", irq, 1'b0);
    host.rd(8'h45, d);
    chk("wake", d, 8'h00);
    host.wr(8'h50, 8'hff, 1'b1);
    host.rd(8'h50, d);
    chk("func", d, 8'hcb);
    host.wr(8'h51, 8'hff, 1'b1);
    host.rd(8'h51, d);
    chk("stamp cfg", d, 8'h7f);
    host.wr(8'h4f, 8'h00, 1'b0);
    host.rd(8'h4f, d);
    chk("trim", d, 8'h80);
    latch = 1'b0;
    host.wr(8'h50, 8'h80, 1'b0);
    evt = 20'h40000;
    tick(2);
    host.rd(8'h45, d);
    chk("wake", d, 8'h20);
    evt = '0;
    tick(2);
    host.rd(8'h45, d);
    chk("wake", d, 8'h00);
    done("flags");
    host.wr(8'h50, 8'h40, 1'b0);
    tick(3 * mesr_pkg::TS_DIV_CYCLES + 20);
    host.rd(8'h40, d);
    chk("timestamp", d, 8'h03);
    host.rd(8'h43, d);
    chk("timestamp", d, 8'h00);
    host.wr(8'h50, 8'h00, 1'b0);
    tick(2000);
    host.rd(8'h40, d);
    chk("timestamp", d, 8'h03);
    done("timestamp");
    sleep = 1'b1;
    for (int p = 0; p < 4; p++) begin
      host.wr(8'h50, 8'(p), 1'b0);
      tick(2);
      chk("power", {lp, gsl, gpd}, {p != 0, p == 2, p == 3});
    end
    sleep = 1'b0;
    tick(2);
    chk("power", {lp, gsl, gpd}, 3'b000);
    chk("rate", rate_o, 2'b10);
    done("power");
    foreach (srows[i]) begin
      pin = srows[i].p;
      host.wr(8'h51, srows[i].c, 1'b0);
      tick(4);
      samp(srows[i].x, srows[i].g, srows[i].k);
    end
    // A pin pulse between samples must survive in latched mode
    host.wr(8'h51, 8'h68, 1'b0);
    pin = 1'b1;
    tick(4);
    pin = 1'b0;
    tick(4);
    samp(16'h1234, 16'h1235, 16'h1234);
    done("stamping");
    nrst_i = 1'b0;
    tick(2);
    nrst_i = 1'b1;
    host.rd(8'h51, d);
    chk("stamp cfg", d, 8'h0e);
    host.rd(8'h40, d);
    chk("timestamp", d, 8'h00);
    done("reset");
    results();
  end
endmodule : motion_event_status_regs_tb
